// file: src/gxp_defs.svh
// constants for the two-wire gpio expander: offsets, resets, timing
`ifndef GXP_DEFS_SVH
`define GXP_DEFS_SVH
// timing, in ns as printed, and cycle counts derived from the clock
`define GXP_CLK_NS 40
`define GXP_TSP_NS 50
`define GXP_SPIKE_CYC ((`GXP_TSP_NS + `GXP_CLK_NS - 1) / `GXP_CLK_NS)
`define GXP_TINT_NS 4000
`define GXP_TINT_CYC (`GXP_TINT_NS / `GXP_CLK_NS)
// fixed upper bits of the bus target address
`define GXP_ADDR_HI 4'h4
// register pointer pairs (pointer bits 2:1)
`define GXP_P_IN 2'h0
`define GXP_P_OUT 2'h1
`define GXP_P_POL 2'h2
`define GXP_P_CFG 2'h3
// reset values
`define GXP_OUT_RST 8'hff
`define GXP_POL_RST 8'h00
`define GXP_CFG_RST 8'hff
// axi byte map: pointer registers at 4 * pointer, then own registers
`define GXP_A_ISTAT 32'h0000_0020
`define GXP_A_IMASK 32'h0000_0024
`define GXP_A_STAT 32'h0000_0028
`define GXP_A_REGMASK 32'hffff_ffe3
// decode classes
`define GXP_D_REG 2'h0
`define GXP_D_ISTAT 2'h1
`define GXP_D_IMASK 2'h2
`define GXP_D_STAT 2'h3
// event bits: port 0 change, port 1 change, bus register write
`define GXP_EV_W 3
`define GXP_EV_WR 2
`define GXP_RESP_OK 2'h0
`define GXP_RESP_ERR 2'h2
`endif

// file: src/gxp_pkg.sv
// types of the two-wire gpio expander
package gxp_pkg;
  typedef enum logic [3:0] {
    GXP_IDLE, GXP_ADDR, GXP_ACKA, GXP_CMD, GXP_ACKC, GXP_WR, GXP_ACKW, GXP_RD, GXP_MACK
  } gxp_i2c_t;
  typedef struct packed {
    logic [1:0] scl_s, sda_s;
    logic [2:0] st_s1, st_s2;
    logic [15:0] pin_s1, pin_s2;
    logic scl_f, sda_f;
    logic [1:0] scl_c, sda_c;
    gxp_i2c_t ist;
    logic [3:0] cnt;
    logic [7:0] sh, tx;
    logic [2:0] ptr;
    logic sda_oe;
    logic [1:0][7:0] outp, pol, cfg;
    logic [15:0] drv, latch;
    logic [1:0] prime, cause_q;
    logic int_oe, irq;
    logic [2:0] istat, imask;
    logic awready, wready, have_aw, have_w, bvalid, arready, rvalid;
    logic [31:0] awa, wd, rdata;
    logic wst;
    logic [1:0] bresp, rresp;
  } gxp_state_t;
endpackage

// file: src/gxp_top.sv
// two-wire bus gpio expander, 16 pins, with an axi4-lite side port
// Functional notes
// - sixteen pins form two 8-bit ports, each with own four registers.
// - each pin's direction follows its direction bit, written by the host.
// - input register holds sampled levels; outputs drive latched output bits.
// - polarity bit set inverts that pin in an input register read.
// - every register, direction, output and polarity too, reads back.
// - change interrupt asserts when an input differs from its held value.
// - change interrupt is active low, open-drain, only pulls low.
// - reset loads register defaults and returns the bus machine to idle.
// - three strap pins form low bits of a fixed target address.
// - after reset all sixteen pins are inputs.
// - works at any serial clock rate up to the maximum; host obeys it.
// - glitches up to the spike limit on clock and data are ignored.
// - interrupt asserts within the valid time after an input change.
// - interrupt releases within the reset time after a clearing edge.
// - byte after address is a pointer, 0 to 7 selecting register pairs.
// - interrupt releases when input returns or its input register is read.
// - reading one port's input clears only that port's cause.
// - writes to input registers are ignored.
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
`include "gxp_defs.svh"
module gxp_top #(
  parameter int ADDR_W = 8
) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // two-wire link
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // address straps
  input wire logic addr_strap_0,
  input wire logic addr_strap_1,
  input wire logic addr_strap_2,
  // port pins
  input wire logic [7:0] port0_pin_in,
  output logic [7:0] port0_pin_out,
  output logic [7:0] port0_pin_oe,
  input wire logic [7:0] port1_pin_in,
  output logic [7:0] port1_pin_out,
  output logic [7:0] port1_pin_oe,
  // interrupts
  output logic int_n_out,
  output logic int_n_oe,
  output logic irq
);
  import gxp_pkg::*;

  localparam int TINT = `GXP_TINT_CYC;
  localparam logic [1:0] SPIKE = 2'(`GXP_SPIKE_CYC);

  // refuse settings the logic cannot serve
  if (ADDR_W < 6 || ADDR_W > 32) $error("gxp_top: ADDR_W must be 6..32");
  if (`GXP_SPIKE_CYC > 2) $error("gxp_top: spike count exceeds filter width");

  gxp_state_t r, n;
  logic scl_rise, scl_fall, start, stop;
  logic [1:0] cause;
  logic [`GXP_EV_W-1:0] ev;
  logic [2:0] wdec, rdec;

  // ************************************************
  // helper functions
  // ************************************************

  // spike filter: level flips only after SPIKE+1 differing samples
  function automatic logic [2:0] filt(input logic f, input logic [1:0] c, input logic s);
    if (s == f)
      return {f, 2'h0};
    else if (c == SPIKE)
      return {s, 2'h0};
    else
      return {f, 2'(c + 2'h1)};
  endfunction

  // register read by pointer, shared by both buses
  function automatic logic [7:0] reg_rd(input gxp_state_t s, input logic [2:0] p);
    unique case (p[2:1])
      `GXP_P_IN: return s.pin_s2[p[0]*8 +: 8] ^ s.pol[p[0]];
      `GXP_P_OUT: return s.outp[p[0]];
      `GXP_P_POL: return s.pol[p[0]];
      `GXP_P_CFG: return s.cfg[p[0]];
    endcase
  endfunction

  // reading an input register re-arms that port with the very value returned,
  // so a pin edge landing in the same cycle still raises the interrupt later
  function automatic gxp_state_t rd_side(input gxp_state_t s, input logic [2:0] p,
                                         input logic [15:0] pins);
    if (p[2:1] == `GXP_P_IN)
      s.latch[p[0]*8 +: 8] = pins[p[0]*8 +: 8];
    return s;
  endfunction

  // register write by pointer; input registers take no write
  function automatic gxp_state_t reg_wr(input gxp_state_t s, input logic [2:0] p,
                                        input logic [7:0] d);
    unique case (p[2:1])
      `GXP_P_IN: ;
      `GXP_P_OUT: s.outp[p[0]] = d;
      `GXP_P_POL: s.pol[p[0]] = d;
      `GXP_P_CFG: s.cfg[p[0]] = d;
    endcase
    return s;
  endfunction

  // axi address decode: {hit, class}
  function automatic logic [2:0] adec(input logic [31:0] a);
    if ((a & `GXP_A_REGMASK) == 32'h0)
      return {1'b1, `GXP_D_REG};
    else if (a == `GXP_A_ISTAT)
      return {1'b1, `GXP_D_ISTAT};
    else if (a == `GXP_A_IMASK)
      return {1'b1, `GXP_D_IMASK};
    else if (a == `GXP_A_STAT)
      return {1'b1, `GXP_D_STAT};
    else
      return 3'h0;
  endfunction

  // start a byte toward the host from pointer p
  function automatic gxp_state_t load(input gxp_state_t s, input logic [2:0] p);
    s.ptr = p;
    s.tx = reg_rd(s, p);
    s = rd_side(s, p, s.pin_s2);
    s.sda_oe = ~s.tx[7];
    s.cnt = 4'h0;
    s.ist = GXP_RD;
    return s;
  endfunction

  // ************************************************
  // next state
  // ************************************************

  // all state in one struct; the whole block is one registered copy
  always_comb
  begin
    n = r;
    ev = '0;
    // two flops on every link, strap and pin input before use
    n.scl_s = {r.scl_s[0], scl_in};
    n.sda_s = {r.sda_s[0], sda_in};
    n.st_s1 = {addr_strap_2, addr_strap_1, addr_strap_0};
    n.st_s2 = r.st_s1;
    n.pin_s1 = {port1_pin_in, port0_pin_in};
    n.pin_s2 = r.pin_s1;
    {n.scl_f, n.scl_c} = filt(r.scl_f, r.scl_c, r.scl_s[1]);
    {n.sda_f, n.sda_c} = filt(r.sda_f, r.sda_c, r.sda_s[1]);
    // edges found by oversampling, so any rate up to the maximum works
    scl_rise = ~r.scl_f & n.scl_f;
    scl_fall = r.scl_f & ~n.scl_f;
    start = r.scl_f & n.scl_f & r.sda_f & ~n.sda_f;
    stop = r.scl_f & n.scl_f & ~r.sda_f & n.sda_f;

    // bus target machine; stop wins and always returns to idle
    if (stop)
    begin
      n.ist = GXP_IDLE;
      n.sda_oe = 1'b0;
    end
    else if (start)
    begin
      n.ist = GXP_ADDR;
      n.cnt = 4'h0;
      n.sda_oe = 1'b0;
    end
    else if (scl_rise)
    begin
      unique case (r.ist)
        GXP_ADDR, GXP_CMD, GXP_WR:
        begin
          n.sh = {r.sh[6:0], r.sda_f};
          n.cnt = r.cnt + 4'h1;
        end
        GXP_RD: n.cnt = r.cnt + 4'h1;
        GXP_MACK: if (r.sda_f) n.ist = GXP_IDLE;
        GXP_IDLE, GXP_ACKA, GXP_ACKC, GXP_ACKW: ;
      endcase
    end
    else if (scl_fall)
    begin
      unique case (r.ist)
        GXP_ADDR:
          if (r.cnt == 4'h8)
          begin
            if (r.sh[7:1] == {`GXP_ADDR_HI, r.st_s2})
            begin
              n.ist = GXP_ACKA;
              n.sda_oe = 1'b1;
            end
            else
              n.ist = GXP_IDLE;
          end
        GXP_ACKA:
        begin
          n.sda_oe = 1'b0;
          n.cnt = 4'h0;
          if (r.sh[0])
            n = load(n, r.ptr);
          else
            n.ist = GXP_CMD;
        end
        GXP_CMD:
          if (r.cnt == 4'h8)
          begin
            n.ptr = r.sh[2:0];
            n.ist = GXP_ACKC;
            n.sda_oe = 1'b1;
          end
        GXP_ACKC, GXP_ACKW:
        begin
          n.sda_oe = 1'b0;
          n.cnt = 4'h0;
          n.ist = GXP_WR;
        end
        GXP_WR:
          if (r.cnt == 4'h8)
          begin
            n = reg_wr(n, r.ptr, r.sh);
            n.ptr = {r.ptr[2:1], ~r.ptr[0]};
            ev[`GXP_EV_WR] = 1'b1;
            n.ist = GXP_ACKW;
            n.sda_oe = 1'b1;
          end
        GXP_RD:
          if (r.cnt == 4'h8)
          begin
            n.sda_oe = 1'b0;
            n.ist = GXP_MACK;
          end
          else
          begin
            n.tx = {r.tx[6:0], 1'b0};
            n.sda_oe = ~r.tx[6];
          end
        GXP_MACK: n = load(n, {r.ptr[2:1], ~r.ptr[0]});
        GXP_IDLE: ;
      endcase
    end

    // axi write: address and data taken in either order
    if (r.awready && s_axi_awvalid)
    begin
      n.awa = 32'(s_axi_awaddr);
      n.have_aw = 1'b1;
    end
    if (r.wready && s_axi_wvalid)
    begin
      n.wd = s_axi_wdata;
      n.wst = s_axi_wstrb[0];
      n.have_w = 1'b1;
    end
    if (r.bvalid && s_axi_bready)
      n.bvalid = 1'b0;
    wdec = adec(r.awa);
    if (r.have_aw && r.have_w && !r.bvalid)
    begin
      n.have_aw = 1'b0;
      n.have_w = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = wdec[2] ? `GXP_RESP_OK : `GXP_RESP_ERR;
      if (wdec[2] && r.wst)
        unique case (wdec[1:0])
          `GXP_D_REG: n = reg_wr(n, r.awa[4:2], r.wd[7:0]);
          `GXP_D_ISTAT: n.istat = n.istat & ~r.wd[2:0];
          `GXP_D_IMASK: n.imask = r.wd[2:0];
          `GXP_D_STAT: ;
        endcase
    end
    n.awready = ~n.have_aw;
    n.wready = ~n.have_w;

    // axi read: one outstanding, answered the cycle after acceptance
    rdec = adec(32'(s_axi_araddr));
    if (r.rvalid && s_axi_rready)
    begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end
    if (r.arready && s_axi_arvalid)
    begin
      n.arready = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = rdec[2] ? `GXP_RESP_OK : `GXP_RESP_ERR;
      n.rdata = 32'h0;
      if (rdec[2])
        unique case (rdec[1:0])
          `GXP_D_REG:
          begin
            n.rdata[7:0] = reg_rd(r, s_axi_araddr[4:2]);
            n = rd_side(n, s_axi_araddr[4:2], r.pin_s2); // same sample as the data
          end
          `GXP_D_ISTAT: n.rdata[2:0] = r.istat;
          `GXP_D_IMASK: n.rdata[2:0] = r.imask;
          `GXP_D_STAT: n.rdata[7:0] = {r.ist != GXP_IDLE, `GXP_ADDR_HI, r.st_s2};
        endcase
    end

    // held values follow the pins for a few cycles after reset
    if (r.prime != 2'h3)
    begin
      n.prime = r.prime + 2'h1;
      n.latch = r.pin_s2;
    end
    // change cause per port, input pins only
    for (int i = 0; i < 2; i++)
      cause[i] = (r.prime == 2'h3) &&
                 |((r.pin_s2[i*8 +: 8] ^ r.latch[i*8 +: 8]) & r.cfg[i]);
    n.cause_q = cause;
    n.int_oe = |cause;
    ev[1:0] = cause & ~r.cause_q;
    // set wins over a clear in the same cycle
    n.istat = n.istat | ev;
    n.irq = |(n.istat & n.imask);
    n.drv = ~{n.cfg[1], n.cfg[0]};
  end

  // ************************************************
  // state register
  // ************************************************

  // synchronous reset loads every default; enable freezes all state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r <= '0;
      r.ist <= GXP_IDLE;
      r.scl_f <= 1'b1;
      r.sda_f <= 1'b1;
      r.scl_s <= 2'h3;
      r.sda_s <= 2'h3;
      r.outp <= {`GXP_OUT_RST, `GXP_OUT_RST};
      r.pol <= {`GXP_POL_RST, `GXP_POL_RST};
      r.cfg <= {`GXP_CFG_RST, `GXP_CFG_RST};
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
    end
    else if (ce)
      r <= n;
  end

  // outputs straight from the state register, except sda_out and int_n_out, which are tied low
  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bresp = r.bresp;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_arready = r.arready;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rvalid = r.rvalid;
  assign sda_out = 1'b0; // open-drain: only ever pulls low
  assign sda_oe = r.sda_oe;
  assign port0_pin_out = r.outp[0];
  assign port1_pin_out = r.outp[1];
  assign port0_pin_oe = r.drv[7:0];
  assign port1_pin_oe = r.drv[15:8];
  assign int_n_out = 1'b0;
  assign int_n_oe = r.int_oe;
  assign irq = r.irq;

  // ************************************************
  // checks
  // ************************************************

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn || !ce);

  AST_INT_SET: assert property (|cause |=> int_n_oe)
    else $error("change interrupt not pulled low");
  AST_INT_TIME: assert property ($changed(r.pin_s2) && |(r.cfg) |-> ##[0:TINT]
    (int_n_oe || (((r.pin_s2 ^ r.latch) & {r.cfg[1], r.cfg[0]}) == 16'h0) ||
    (r.prime != 2'h3)))
    else $error("change interrupt late");
  AST_DIR_RST: assert property ($rose(aresetn) |-> port0_pin_oe == 8'h0 && port1_pin_oe == 8'h0)
    else $error("pins not inputs after reset");
  AST_POL_READ: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == '0
    |=> s_axi_rdata[7:0] == ($past(r.pin_s2[7:0]) ^ $past(r.pol[0])))
    else $error("input read ignores polarity");
  AST_CLR_ONE: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == '0
    |=> r.latch[7:0] == $past(r.pin_s2[7:0]) && $stable(r.latch[15:8]))
    else $error("input read cleared wrong port");
  AST_SPIKE: assert property ($changed(r.scl_f) |-> $past(r.scl_s[1], 1) == r.scl_f &&
    $past(r.scl_s[1], 2) == r.scl_f && $past(r.scl_s[1], 3) == r.scl_f)
    else $error("clock glitch passed filter");
  AST_STOP_IDLE: assert property (stop |=> r.ist == GXP_IDLE && !sda_oe)
    else $error("stop did not return to idle");
  AST_ADDR_HIT: assert property (r.ist == GXP_ADDR && r.cnt == 4'h8 && scl_fall && !stop &&
    !start && r.sh[7:1] == {`GXP_ADDR_HI, r.st_s2} |=> r.ist == GXP_ACKA && sda_oe)
    else $error("own address not acknowledged");
  AST_IN_RO: assert property (r.ist == GXP_WR && r.cnt == 4'h8 && scl_fall && !stop && !start
    && r.ptr[2:1] == `GXP_P_IN |=> $stable(r.outp) && $stable(r.cfg) && $stable(r.pol))
    else $error("input register took a write");
  AST_OE_CFG: assert property (s_axi_bvalid && !$past(s_axi_bvalid) && s_axi_bresp == 2'h0
    |-> port0_pin_oe == ~r.cfg[0] && port1_pin_oe == ~r.cfg[1])
    else $error("pin drive not following direction");
  AST_IRQ: assert property ((r.istat & r.imask) != 3'h0 |-> irq)
    else $error("unmasked event without interrupt");

  COV_I2C_WR: cover property (r.ist == GXP_WR ##1 r.ist == GXP_ACKW);
  COV_I2C_RD: cover property (r.ist == GXP_RD ##1 r.ist == GXP_MACK);
  COV_INT: cover property ($rose(int_n_oe));
  COV_AXI_WR: cover property (s_axi_bvalid && s_axi_bready);
endmodule

// file: tb/gxp_host.sv
// two-wire bus controller model that drives the expander's link
`timescale 1ns/10ps
module gxp_host (
  // link lines, data is open-drain with a pull-up
  output logic scl,
  output logic sda_low,
  input wire logic sda_line
);
  // ****************
  // bit timing
  // ****************
  // 2560 ns per bit stays under the top serial rate
  localparam int HQ = 640;
  // idle bus: clock stands high, data released
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // data moves mid-low, sampled late in high to allow the filter lag
  task automatic bit_io(input logic b, output logic s);
    #HQ sda_low = ~b;
    #HQ scl = 1'b1;
    #(2*HQ) s = sda_line;
    scl = 1'b0;
  endtask
  // start, address, pointer byte, one data byte, stop; quits on a refusal
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                    output logic ok);
    logic [26:0] v;
    logic s;
    v = {a, 1'b0, 1'b1, p, 1'b1, d, 1'b1};
    ok = 1'b1;
    #(2*HQ+7) sda_low = 1'b1;
    #(2*HQ) scl = 1'b0;
    for (int i = 26; i >= 0; i--)
    begin
      bit_io(v[i], s);
      if (i % 9 == 0 && s)
        ok = 1'b0;
      if (!ok)
        break;
    end
    #HQ sda_low = 1'b1;
    #HQ scl = 1'b1;
    #(2*HQ) sda_low = 1'b0;
    #(2*HQ);
  endtask
  // start, address with read, one byte from the pointer, refusal of more, stop
  task automatic rd(input logic [6:0] a, output logic [7:0] q, output logic ok);
    logic [8:0] v;
    logic s;
    v = {a, 1'b1, 1'b1};
    #(2*HQ+7) sda_low = 1'b1;
    #(2*HQ) scl = 1'b0;
    for (int i = 8; i >= 0; i--)
      bit_io(v[i], s);
    ok = ~s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, q[i]);
    bit_io(1'b1, s);
    #HQ sda_low = 1'b1;
    #HQ scl = 1'b1;
    #(2*HQ) sda_low = 1'b0;
    #(2*HQ);
  endtask
endmodule

// file: tb/testbench.sv
// self-checking bench of the expander: registers, pins, interrupt, link
`timescale 1ns/10ps
`include "gxp_defs.svh"
module testbench;
  // ****************
  // signals
  // ****************
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [2:0] strap = 3'h0;
  logic [7:0] p0_ext = 8'h3c, p1_ext = 8'hc3, pol0 = 8'h00, d, c;
  logic awready, wready, bvalid, arready, rvalid, sda_out, sda_oe, int_n_out;
  logic int_n_oe, irq, scl, host_low, ok;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] p0_in, p0_out, p0_oe, p1_in, p1_out, p1_oe;
  logic [7:0] rst_v [8] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00};
  logic [33:0] rq[$], bq[$];
  int err_total = 0, compares = 0, cyc = 0, n;
  // open-drain data line and pins that show their own drive when outputs
  wire sda_line = ~(host_low | (sda_oe & ~sda_out));
  assign p0_in = (p0_oe & p0_out) | (~p0_oe & p0_ext);
  assign p1_in = (p1_oe & p1_out) | (~p1_oe & p1_ext);
  always #20 aclk = ~aclk;
  gxp_top #(.ADDR_W(8)) u_gxp_top (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_strap_0(strap[0]), .addr_strap_1(strap[1]), .addr_strap_2(strap[2]),
    .port0_pin_in(p0_in), .port0_pin_out(p0_out), .port0_pin_oe(p0_oe),
    .port1_pin_in(p1_in), .port1_pin_out(p1_out), .port1_pin_oe(p1_oe),
    .int_n_out(int_n_out), .int_n_oe(int_n_oe), .irq(irq));
  gxp_host u_gxp_host (.scl(scl), .sda_low(host_low), .sda_line(sda_line));
  // ****************
  // checking
  // ****************
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("compares %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // answers are taken off the queues as their handshakes complete
  always @(posedge aclk)
  begin
    if (rvalid && rready)
      check({rresp, rdata}, rq.pop_front());
    if (bvalid && bready)
      check({32'h0, bresp}, bq.pop_front());
  end
  // a hang ends the run as a failure
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      err_total++;
      close_out();
    end
  end
  // ****************
  // bus tasks, entered just after a rising edge
  // ****************
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    bq.push_back({32'h0, r});
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bready && bvalid)
        bready <= 1'b0;
    end while (awvalid || wvalid || bready);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    rq.push_back({r, v});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rready && rvalid)
        rready <= 1'b0;
    end while (arvalid || rready);
  endtask
  // the change output must follow within the valid or reset time
  task automatic wait_int(input logic lvl);
    n = 0;
    while (int_n_oe !== lvl && n < 400)
    begin
      @(posedge aclk);
      n++;
    end
    check(34'(n <= `GXP_TINT_CYC), 34'h1);
  endtask
  // ****************
  // tests
  // ****************
  initial
  begin
    void'($urandom(32'h0db89400));
    strap <= 3'($urandom);
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({18'h0, p0_oe, p1_oe}, 34'h0);
    check({18'h0, p0_out, p1_out}, 34'hffff);
    check({32'h0, int_n_oe, int_n_out}, 34'h0);
    for (int i = 0; i < 8; i++)
      axi_rd(8'(8 + 4 * i), {24'h0, rst_v[i]}, `GXP_RESP_OK);
    $display("test reset over");
    p0_ext <= 8'($urandom);
    p1_ext <= 8'($urandom);
    pol0 = 8'($urandom);
    repeat (4) @(posedge aclk);
    axi_wr(8'h10, {24'h0, pol0}, `GXP_RESP_OK);
    axi_wr(8'h00, 32'hff, `GXP_RESP_OK);
    axi_rd(8'h00, {24'h0, p0_ext ^ pol0}, `GXP_RESP_OK);
    axi_rd(8'h04, {24'h0, p1_ext}, `GXP_RESP_OK);
    axi_wr(8'h24, 32'h7, `GXP_RESP_OK);
    axi_wr(8'h20, 32'h7, `GXP_RESP_OK);
    $display("test inputs over");
    p0_ext <= p0_ext ^ 8'h01;
    wait_int(1'b1);
    repeat (3) @(posedge aclk);
    check({33'h0, irq}, 34'h1);
    p0_ext <= p0_ext ^ 8'h01;
    wait_int(1'b0);
    p0_ext <= p0_ext ^ 8'h80;
    p1_ext <= p1_ext ^ 8'h02;
    wait_int(1'b1);
    axi_rd(8'h00, {24'h0, p0_ext ^ pol0}, `GXP_RESP_OK);
    repeat (8) @(posedge aclk);
    check({33'h0, int_n_oe}, 34'h1);
    axi_rd(8'h04, {24'h0, p1_ext}, `GXP_RESP_OK);
    wait_int(1'b0);
    axi_rd(8'h20, 32'h3, `GXP_RESP_OK);
    axi_wr(8'h20, 32'h3, `GXP_RESP_OK);
    repeat (2) @(posedge aclk);
    check({33'h0, irq}, 34'h0);
    axi_wr(8'h24, 32'h0, `GXP_RESP_OK);
    p1_ext <= p1_ext ^ 8'h10;
    wait_int(1'b1);
    repeat (4) @(posedge aclk);
    check({33'h0, irq}, 34'h0);
    axi_rd(8'h20, 32'h2, `GXP_RESP_OK);
    axi_rd(8'h04, {24'h0, p1_ext}, `GXP_RESP_OK);
    axi_wr(8'h20, 32'h7, `GXP_RESP_OK);
    // a low enable freezes the synchronisers, so a change waits for it
    ce <= 1'b0;
    p0_ext <= p0_ext ^ 8'h04;
    repeat (10) @(posedge aclk);
    check({33'h0, int_n_oe}, 34'h0);
    ce <= 1'b1;
    wait_int(1'b1);
    axi_rd(8'h00, {24'h0, p0_ext ^ pol0}, `GXP_RESP_OK);
    axi_wr(8'h20, 32'h7, `GXP_RESP_OK);
    $display("test interrupt over");
    axi_rd(8'h2c, 32'h0, `GXP_RESP_ERR);
    axi_wr(8'h30, 32'h1, `GXP_RESP_ERR);
    axi_rd(8'h28, {24'h0, 1'b0, `GXP_ADDR_HI, strap}, `GXP_RESP_OK);
    d = 8'($urandom);
    u_gxp_host.wr({`GXP_ADDR_HI, strap}, 8'h02, d, ok);
    check({33'h0, ok}, 34'h1);
    repeat (10) @(posedge aclk);
    check({26'h0, p0_out}, {26'h0, d});
    u_gxp_host.wr({`GXP_ADDR_HI, strap ^ 3'h5}, 8'h02, ~d, ok);
    check({33'h0, ok}, 34'h0);
    repeat (10) @(posedge aclk);
    check({26'h0, p0_out}, {26'h0, d});
    u_gxp_host.wr({`GXP_ADDR_HI, strap}, 8'h00, ~d, ok);
    check({33'h0, ok}, 34'h1);
    repeat (10) @(posedge aclk);
    check({26'h0, p0_out}, {26'h0, d});
    p1_ext <= p1_ext ^ 8'h40;
    wait_int(1'b1);
    u_gxp_host.rd({`GXP_ADDR_HI, strap}, c, ok);
    check({25'h0, ok, c}, {25'h0, 1'b1, p1_ext});
    check({33'h0, int_n_oe}, 34'h0);
    axi_rd(8'h20, 32'h6, `GXP_RESP_OK);
    $display("test link over");
    d = 8'($urandom);
    c = 8'($urandom);
    axi_wr(8'h08, {24'h0, d}, `GXP_RESP_OK);
    axi_wr(8'h18, {24'h0, c}, `GXP_RESP_OK);
    axi_wr(8'h1c, 32'h0, `GXP_RESP_OK);
    check({26'h0, p0_oe}, {26'h0, ~c});
    check({26'h0, p1_oe}, 34'hff);
    check({26'h0, p0_out}, {26'h0, d});
    repeat (4) @(posedge aclk);
    axi_rd(8'h18, {24'h0, c}, `GXP_RESP_OK);
    axi_rd(8'h00, {24'h0, ((~c & d) | (c & p0_ext)) ^ pol0}, `GXP_RESP_OK);
    $display("test direction over");
    close_out();
  end
endmodule
